/* File: ccsb_pkg.sv */
// Package of constants and types for the carry-condition short branch unit.
`default_nettype none
package ccsb_pkg;
   localparam logic [7:0] OPC_NO_CARRY = 8'h73;
   localparam logic [7:0] OPC_ON_CARRY = 8'h72;
   localparam logic [7:0] OPC_BELOW_OR_EQUAL = 8'h76;
   localparam logic [15:0] SIGN_FILL_NEG = 16'hff00;
   localparam logic [15:0] SIGN_FILL_POS = 16'h00ff;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [3:0] CLOCKS_TAKEN = 4'hd;
   localparam logic [3:0] CLOCKS_NOT_TAKEN = 4'h4;
   localparam logic [15:0] INSTR_LEN = 16'h0002;
   typedef enum logic [1:0] {
      CCSB_IDLE,
      CCSB_WAIT_DISP,
      CCSB_BUSY
   } ccsb_state_t;
endpackage
`default_nettype wire

/* File: ccsb_branch.sv */
// Decode and execute unit for the carry-condition short branches.
`default_nettype none
// Overview of operation
// - Opcode 73 hex branches only when carry flag is clear.
// - Opcode 72 hex branches only when carry flag is set.
// - Opcode 76 hex branches when carry or zero flag is set.
// - Each opcode is followed by exactly one signed displacement byte.
// - Displacement is sign-extended to 16 bits before use.
// - Taken branch adds displacement to instruction pointer; segment untouched.
// - Untaken branch continues at the instruction after the two bytes.
// - Synonym names share one opcode and behave identically.
// - Each branch takes 13 or 4 clocks on every bus width.
// - Reach is limited to the signed byte displacement range.
module ccsb_branch (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic OPCODE_VALID_IN,
   input wire logic [7:0] OPCODE_IN,
   input wire logic DISP_VALID_IN,
   input wire logic [7:0] DISP_IN,
   input wire logic CARRY_FLAG_IN,
   input wire logic ZERO_FLAG_IN,
   input wire logic [15:0] PTR_IN,
   output logic OPCODE_ACCEPT_OUT,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic TAKEN_OUT,
   output logic PTR_LOAD_OUT,
   output logic [15:0] PTR_OUT,
   output logic QUEUE_FLUSH_OUT
);

   typedef struct packed {
      ccsb_pkg::ccsb_state_t state;
      logic [1:0] kind;
      logic [15:0] base;
      logic [3:0] count;
      logic accept;
      logic busy;
      logic done;
      logic taken;
      logic ptr_load;
      logic [15:0] ptr;
      logic flush;
   } ccsb_regs_t;

   ccsb_regs_t state_r;
   ccsb_regs_t state_nxt;

   // Only the opcode byte is seen, so every synonym decodes the same way.
   function automatic logic [1:0] ccsb_decode(input logic [7:0] opc);
      case (opc)
         ccsb_pkg::OPC_NO_CARRY: ccsb_decode = 2'h1;
         ccsb_pkg::OPC_ON_CARRY: ccsb_decode = 2'h2;
         ccsb_pkg::OPC_BELOW_OR_EQUAL: ccsb_decode = 2'h3;
         default: ccsb_decode = 2'h0;
      endcase
   endfunction

   function automatic logic ccsb_cond(input logic [1:0] kind, input logic cf, input logic zf);
      case (kind)
         2'h1: ccsb_cond = !cf;
         2'h2: ccsb_cond = cf;
         2'h3: ccsb_cond = cf | zf;
         default: ccsb_cond = 1'b0;
      endcase
   endfunction

   // Eight-bit operand only, which is why reach stops near 128 bytes.
   function automatic logic [15:0] ccsb_sext(input logic [7:0] d);
      if (d[7]) begin
         ccsb_sext = ccsb_pkg::SIGN_FILL_NEG | {8'h00, d};
      end else begin
         ccsb_sext = ccsb_pkg::SIGN_FILL_POS & {8'h00, d};
      end
   endfunction

   logic cond_now;
   logic [15:0] next_seq;
   assign cond_now = ccsb_cond(state_r.kind, CARRY_FLAG_IN, ZERO_FLAG_IN);
   assign next_seq = state_r.base + ccsb_pkg::INSTR_LEN;

   always_comb begin
      state_nxt = state_r;
      state_nxt.accept = 1'b0;
      state_nxt.done = 1'b0;
      state_nxt.ptr_load = 1'b0;
      state_nxt.flush = 1'b0;
      case (state_r.state)
         ccsb_pkg::CCSB_IDLE: begin
            if (OPCODE_VALID_IN && ccsb_decode(OPCODE_IN) != 2'h0) begin
               state_nxt.kind = ccsb_decode(OPCODE_IN);
               state_nxt.base = PTR_IN;
               state_nxt.accept = 1'b1;
               state_nxt.busy = 1'b1;
               state_nxt.state = ccsb_pkg::CCSB_WAIT_DISP;
            end
         end
         ccsb_pkg::CCSB_WAIT_DISP: begin
            if (DISP_VALID_IN) begin
               state_nxt.taken = cond_now;
               if (cond_now) begin
                  // Displacement is relative to the next instruction; sum wraps in 16 bits.
                  state_nxt.ptr = next_seq + ccsb_sext(DISP_IN);
                  state_nxt.flush = 1'b1;
                  state_nxt.count = ccsb_pkg::CLOCKS_TAKEN - 4'h2;
               end else begin
                  state_nxt.ptr = next_seq;
                  state_nxt.count = ccsb_pkg::CLOCKS_NOT_TAKEN - 4'h2;
               end
               state_nxt.state = ccsb_pkg::CCSB_BUSY;
            end
         end
         ccsb_pkg::CCSB_BUSY: begin
            state_nxt.count = state_r.count - 4'h1;
            if (state_r.count == 4'h1) begin
               state_nxt.done = 1'b1;
               state_nxt.ptr_load = 1'b1;
               state_nxt.busy = 1'b0;
               state_nxt.state = ccsb_pkg::CCSB_IDLE;
            end
         end
         default: begin
            state_nxt.state = ccsb_pkg::CCSB_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         state_r <= '{state: ccsb_pkg::CCSB_IDLE, kind: 2'h0, base: ccsb_pkg::PTR_RESET, count: 4'h0,
                      accept: 1'b0, busy: 1'b0, done: 1'b0, taken: 1'b0, ptr_load: 1'b0,
                      ptr: ccsb_pkg::PTR_RESET, flush: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign OPCODE_ACCEPT_OUT = state_r.accept;
   assign BUSY_OUT = state_r.busy;
   assign DONE_OUT = state_r.done;
   assign TAKEN_OUT = state_r.taken;
   assign PTR_LOAD_OUT = state_r.ptr_load;
   assign PTR_OUT = state_r.ptr;
   assign QUEUE_FLUSH_OUT = state_r.flush;

   // Helper counting cycles from the displacement edge to done, so a late byte only shifts the start.
   logic [4:0] span_r;
   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         span_r <= 5'h00;
      end else if (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN) begin
         span_r <= 5'h02;
      end else if (state_r.busy) begin
         span_r <= span_r + 5'h01;
      end
   end

   taken_span_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (DONE_OUT && TAKEN_OUT)
      |-> span_r == 5'h0d)
      else $error("taken branch length wrong");

   fall_span_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (DONE_OUT && !TAKEN_OUT)
      |-> span_r == 5'h04)
      else $error("untaken branch length wrong");

   no_carry_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && state_r.kind == 2'h1)
      |=> TAKEN_OUT == !$past(CARRY_FLAG_IN))
      else $error("no-carry condition wrong");

   on_carry_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && state_r.kind == 2'h2)
      |=> TAKEN_OUT == $past(CARRY_FLAG_IN))
      else $error("carry condition wrong");

   below_eq_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && state_r.kind == 2'h3)
      |=> TAKEN_OUT == ($past(CARRY_FLAG_IN) | $past(ZERO_FLAG_IN)))
      else $error("carry-or-zero condition wrong");

   target_calc_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && cond_now)
      |=> PTR_OUT == 16'($past(state_r.base) + 16'h0002 + {{8{$past(DISP_IN[7])}}, $past(DISP_IN)}))
      else $error("branch target wrong");

   fall_through_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && !cond_now)
      |=> PTR_OUT == 16'($past(state_r.base) + 16'h0002))
      else $error("fall-through address wrong");

   accept_decode_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_IDLE && OPCODE_VALID_IN && OPCODE_IN inside {8'h72, 8'h73, 8'h76})
      |=> OPCODE_ACCEPT_OUT ##1 BUSY_OUT)
      else $error("branch opcode not accepted");

   flush_taken_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      QUEUE_FLUSH_OUT
      |-> TAKEN_OUT && BUSY_OUT)
      else $error("flush without taken branch");

   accept_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      OPCODE_ACCEPT_OUT
      |=> !OPCODE_ACCEPT_OUT)
      else $error("accept longer than one cycle");

   accept_busy_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      OPCODE_ACCEPT_OUT
      |-> BUSY_OUT && !DONE_OUT)
      else $error("accept without busy");

   refuse_busy_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state != ccsb_pkg::CCSB_IDLE && OPCODE_VALID_IN)
      |=> !OPCODE_ACCEPT_OUT)
      else $error("opcode accepted while busy");

   ignore_other_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_IDLE && OPCODE_VALID_IN && !(OPCODE_IN inside {8'h72, 8'h73, 8'h76}))
      |=> !OPCODE_ACCEPT_OUT)
      else $error("foreign opcode accepted");

   wait_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && !DISP_VALID_IN)
      |=> state_r.state == ccsb_pkg::CCSB_WAIT_DISP && BUSY_OUT)
      else $error("left wait without displacement");

   sext_neg_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && cond_now && DISP_IN[7])
      |=> (16'(PTR_OUT - $past(next_seq)) & 16'hff00) == 16'hff00)
      else $error("negative displacement not filled with ones");

   sext_pos_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && cond_now && !DISP_IN[7])
      |=> (16'(PTR_OUT - $past(next_seq)) & 16'hff00) == 16'h0000)
      else $error("positive displacement not filled with zeros");

   reach_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && cond_now)
      |=> 16'(PTR_OUT - $past(next_seq)) inside {[16'hff80:16'hffff], [16'h0000:16'h007f]})
      else $error("branch beyond short reach");

   done_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      DONE_OUT
      |=> !DONE_OUT)
      else $error("done longer than one cycle");

   done_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      DONE_OUT
      |-> !BUSY_OUT && state_r.state == ccsb_pkg::CCSB_IDLE)
      else $error("done while still busy");

   load_with_done_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      PTR_LOAD_OUT
      |-> DONE_OUT)
      else $error("pointer load without done");

   done_with_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      DONE_OUT
      |-> PTR_LOAD_OUT)
      else $error("done without pointer load");

   flush_pulse_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      QUEUE_FLUSH_OUT
      |=> !QUEUE_FLUSH_OUT)
      else $error("flush longer than one cycle");

   flush_first_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && cond_now)
      |=> QUEUE_FLUSH_OUT && TAKEN_OUT)
      else $error("taken branch did not flush");

   fall_no_flush_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN && !cond_now)
      |=> !QUEUE_FLUSH_OUT && !TAKEN_OUT)
      else $error("untaken branch flushed");

   result_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !(state_r.state == ccsb_pkg::CCSB_WAIT_DISP && DISP_VALID_IN)
      |=> $stable(TAKEN_OUT) && $stable(PTR_OUT))
      else $error("result changed outside a branch");

   busy_rise_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      $rose(BUSY_OUT)
      |-> OPCODE_ACCEPT_OUT)
      else $error("busy rose without accept");

   busy_fall_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      $fell(BUSY_OUT)
      |-> DONE_OUT)
      else $error("busy fell without done");

   count_bound_a: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      state_r.state == ccsb_pkg::CCSB_BUSY
      |-> state_r.count != 4'h0 && state_r.count < ccsb_pkg::CLOCKS_TAKEN)
      else $error("cycle counter out of range");

   taken_c: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN) DONE_OUT && TAKEN_OUT);
   fall_c: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN) DONE_OUT && !TAKEN_OUT);
   back_c: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN) PTR_LOAD_OUT && TAKEN_OUT && PTR_OUT < state_r.base);
   late_c: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN) state_r.state == ccsb_pkg::CCSB_WAIT_DISP && !DISP_VALID_IN);
   wrap_c: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN) DONE_OUT && state_r.base > 16'hff00 && PTR_OUT < 16'h0100);
endmodule
`default_nettype wire

/* File: ccsb_fetch_model.sv */
// Behavioural model of the fetch stage and flags register that feed the branch unit.
`default_nettype none
module ccsb_fetch_model (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [7:0] op_in,
   input wire logic [7:0] disp_in,
   input wire logic [1:0] flags_in,
   input wire logic [1:0] late_in,
   output logic op_valid_out,
   output logic [7:0] op_out,
   output logic disp_valid_out,
   output logic [7:0] disp_out,
   output logic [1:0] flags_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend_r = 1'b0;
   logic [1:0] wait_r = 2'h0;
   initial begin
      op_valid_out = 1'b0;
      op_out = 8'h00;
      disp_valid_out = 1'b0;
      disp_out = 8'h00;
      flags_out = 2'h0;
   end
   always @(posedge clk_in) begin
      op_valid_out <= 1'b0;
      disp_valid_out <= 1'b0;
      // Released bytes toggle, so a stale byte can never pass for a fresh one.
      op_out <= ~op_out;
      disp_out <= ~disp_out;
      if (go_in) begin
         op_valid_out <= 1'b1;
         op_out <= op_in;
         flags_out <= flags_in;
         wait_r <= late_in;
         pend_r <= 1'b1;
      end else if (pend_r && wait_r == 2'h0) begin
         disp_valid_out <= 1'b1;
         disp_out <= disp_in;
         pend_r <= 1'b0;
      end else if (pend_r) begin
         wait_r <= wait_r - 2'h1;
      end
   end
endmodule
`default_nettype wire

/* File: carry_cond_short_branch_tb_top.sv */
// Self-checking testbench of the carry-condition short branch unit.
`default_nettype none
module carry_cond_short_branch_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic [7:0] op = 8'h00;
   logic [7:0] disp = 8'h00;
   logic [1:0] flags = 2'h0;
   logic [1:0] late = 2'h0;
   logic [15:0] ptr = 16'h0000;
   logic ov, dv, acc, busy, done, tk, ld, fl;
   logic [7:0] ob, db;
   logic [1:0] fo;
   logic [15:0] ptr_o;
   int n_fail = 0;
   int total_checks = 0;
   ccsb_fetch_model ccsb_fetch_model_i (.clk_in(clk), .go_in(go), .op_in(op), .disp_in(disp), .flags_in(flags),
      .late_in(late), .op_valid_out(ov), .op_out(ob), .disp_valid_out(dv), .disp_out(db), .flags_out(fo));
   ccsb_branch ccsb_branch_i (.CORE_CLK_IN(clk), .RESET_IN(rst), .OPCODE_VALID_IN(ov), .OPCODE_IN(ob),
      .DISP_VALID_IN(dv), .DISP_IN(db), .CARRY_FLAG_IN(fo[1]), .ZERO_FLAG_IN(fo[0]), .PTR_IN(ptr),
      .OPCODE_ACCEPT_OUT(acc), .BUSY_OUT(busy), .DONE_OUT(done), .TAKEN_OUT(tk), .PTR_LOAD_OUT(ld),
      .PTR_OUT(ptr_o), .QUEUE_FLUSH_OUT(fl));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One branch: flags are {carry, zero}; the count runs from accept to done.
   task automatic run(input logic [7:0] o, input logic [7:0] d, input logic [1:0] f, input logic [15:0] a,
      input logic t, input logic [1:0] lt);
      int n;
      logic seen_fl;
      @(posedge clk);
      go <= 1'b1;
      op <= o;
      disp <= d;
      flags <= f;
      ptr <= a;
      late <= lt;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (acc !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      check(busy, 1'b1);
      n = 0;
      seen_fl = 1'b0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
         seen_fl |= fl;
      end
      check(16'(n), 16'(t ? ccsb_pkg::CLOCKS_TAKEN - 1 + lt : ccsb_pkg::CLOCKS_NOT_TAKEN - 1 + lt));
      check(tk, t);
      check(ld, 1'b1);
      check(busy, 1'b0);
      check(seen_fl, t);
      check(ptr_o, t ? a + 16'h0002 + {{8{d[7]}}, d} : a + 16'h0002);
   endtask
   // A second opcode offered mid-branch is dropped, and the first branch still completes.
   task automatic t_refused();
      int n;
      int n_acc;
      @(posedge clk);
      go <= 1'b1;
      op <= 8'h72;
      disp <= 8'h04;
      flags <= 2'h2;
      ptr <= 16'h3000;
      late <= 2'h0;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      go <= 1'b1;
      op <= 8'h73;
      @(posedge clk);
      go <= 1'b0;
      n_acc = 0;
      for (n = 0; n < 16; n++) begin
         @(negedge clk);
         if (acc === 1'b1) n_acc++;
      end
      check(16'(n_acc), 16'h0000);
      check(ptr_o, 16'h3006);
   endtask
   task automatic t_no_carry();
      run(8'h73, 8'h7f, 2'h0, 16'h1000, 1'b1, 2'h0);
      run(8'h73, 8'h10, 2'h2, 16'h1000, 1'b0, 2'h0);
      run(8'h73, 8'h05, 2'h1, 16'hffff, 1'b1, 2'h2);
   endtask
   task automatic t_on_carry();
      run(8'h72, 8'h80, 2'h2, 16'h0040, 1'b1, 2'h0);
      run(8'h72, 8'h80, 2'h1, 16'h0040, 1'b0, 2'h1);
   endtask
   task automatic t_below_eq();
      run(8'h76, 8'hfe, 2'h2, 16'h2000, 1'b1, 2'h0);
      run(8'h76, 8'h03, 2'h1, 16'h2000, 1'b1, 2'h0);
      run(8'h76, 8'h03, 2'h0, 16'h2000, 1'b0, 2'h0);
   endtask
   task automatic t_ignored();
      int n;
      logic seen_acc;
      @(posedge clk);
      go <= 1'b1;
      op <= 8'h74;
      @(posedge clk);
      go <= 1'b0;
      seen_acc = 1'b0;
      for (n = 0; n < 6; n++) begin
         @(negedge clk);
         seen_acc |= acc;
      end
      check(seen_acc, 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_no_carry();
      t_on_carry();
      t_below_eq();
      t_refused();
      t_ignored();
      summarize();
   end
   initial begin
      #(25 * 3000);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
